// [fx_port.sv]
// One 100 Mb/s fiber port: strap decode, 4B5B/NRZI transmit, receive
// decode, link detection from data and far-end fault handling, APB regs.
// Assumes all inputs synchronous to CLK_SYS and a held APB request.
//
// How it works
// RQ1: strap 00 none, 01 port 7, 10 ports 6-7, 11 all ports fiber.
// RQ2: board holds loopback strap low when fiber is selected.
// RQ3: fiber port never auto-negotiates; both ends set alike.
// RQ4: fiber transmit uses 4B5B without scrambling, output as NRZI.
// RQ5: fiber receive bits go straight to symbol decoding, no descrambler.
// RQ6: link up on a valid link word, down while none is seen.
// RQ7: link comes only from received data, never signal detect.
// RQ8: fault pattern is exactly 84 ones followed by one zero.
// RQ9: three received fault patterns set remote fault, status bit 4.
// RQ10: without valid receive link the port sends the fault pattern.
// RQ11: fault generation, detection and meaning only on fiber ports.
// RQ12: frame start sends J K in place of two nibbles; end T R.
// RQ13: between frames idle code-groups are sent continuously.
// RQ14: NRZI toggles on one, holds on zero; decode change as one.
// RQ15: detector counts ones; zero after exactly 84 ones is a hit.
//
// Chosen here: the placing of the registers and register access over APB.
`timescale 1ns/1ps
`include "fx_cfg.svh"

module fx_port
#(
    parameter int PORT_ID = 7,
    parameter int BIT_DIV = `BIT_DIV,
    parameter int LOSS_BITS = `LOSS_BITS,
    parameter int LINK_ONES = `LINK_ONES
)
(
    input wire logic CLK_SYS,
    input wire logic RESET,
    input wire logic PSEL,
    input wire logic PENABLE,
    input wire logic PWRITE,
    input wire logic [11:0] PADDR,
    input wire logic [31:0] PWDATA,
    output logic PREADY,
    output logic [31:0] PRDATA,
    output logic PSLVERR,
    input wire logic [1:0] MEDIUM_SELECT_STRAP,
    input wire logic PORT_PAIR_LOOPBACK_STRAP,
    input wire logic TX_EN,
    input wire logic [3:0] TXD,
    output logic TX_TAKE,
    output logic FX_TX_LINE,
    input wire logic FX_RX_LINE,
    output logic RX_DV,
    output logic [3:0] RXD,
    output logic RX_ERR,
    input wire logic RX_READY,
    output logic LINK_UP,
    output logic FIBER_MODE
);

    fx_pkg::core_s s;
    fx_pkg::core_s n;

    logic bit_en;
    logic tx_bit;
    logic rx_bit;
    logic fault_tx;
    logic [9:0] sh;
    logic [4:0] sym;
    logic [31:0] status;
    logic fifo_in_valid;
    logic fifo_in_ready;
    fx_pkg::rx_word_s fifo_in;
    logic fifo_out_valid;
    logic fifo_out_ready;
    fx_pkg::rx_word_s fifo_out;
    logic acc;

    // ----------------------------------------
    // Line coder and receive buffer
    // ----------------------------------------
    fx_nrzi u_nrzi
    (
        .clk(CLK_SYS),
        .rst(RESET),
        .bit_en(bit_en),
        .tx_on(s.fiber),
        .tx_bit(tx_bit),
        .rx_line(FX_RX_LINE),
        .tx_line(FX_TX_LINE),
        .rx_bit(rx_bit)
    );

    // The line cannot be stalled, so a full buffer drops and flags it
    fx_fifo #(.W(`FIFO_WIDTH), .D(`FIFO_DEPTH)) u_fifo
    (
        .clk(CLK_SYS),
        .rst(RESET),
        .in_valid(fifo_in_valid),
        .in_ready(fifo_in_ready),
        .in_data(fifo_in),
        .out_valid(fifo_out_valid),
        .out_ready(fifo_out_ready),
        .out_data(fifo_out)
    );

    // ----------------------------------------
    // Next state
    // ----------------------------------------
    always_comb
    begin
        n = s;
        n.tx_take = 1'b0;
        sh = s.rx_sh;
        sym = s.rx_sh[4:0];
        fifo_in_valid = 1'b0;
        fifo_in = '0;
        tx_bit = 1'b0;
        acc = PSEL && PENABLE;

        // Straps are caught once, in the first cycle after reset release
        if (!s.init)
        begin
            n.init = 1'b1;
            case (MEDIUM_SELECT_STRAP) // [RQ1]
                2'b01: n.fiber = (PORT_ID == 7);
                2'b10: n.fiber = (PORT_ID >= 6);
                2'b11: n.fiber = 1'b1;
                default: n.fiber = 1'b0;
            endcase
            // A loopback strap left high keeps the port on copper
            if (PORT_PAIR_LOOPBACK_STRAP)
                n.fiber = 1'b0; // [RQ2]
        end

        bit_en = (s.div == 8'(BIT_DIV - 1));
        n.div = bit_en ? 8'h00 : s.div + 8'h01;

        status = '0;
        status[`ST_LINK] = s.link;
        status[`ST_ANEG] = !s.fiber; // [RQ3]
        status[`ST_RFAULT] = s.rfault && s.fiber; // [RQ11]
        status[`ST_FIBER] = s.fiber;
        status[`ST_OVFL] = s.ovfl;

        // ----------------------------------------
        // APB slave: answer one cycle into the access phase
        // ----------------------------------------
        if (acc && !s.pready)
        begin
            n.pready = 1'b1;
            n.pslverr = 1'b0;
            case (PADDR)
                `OFS_CTRL: n.prdata = {30'h0, s.ctrl};
                `OFS_STATUS: n.prdata = status;
                default:
                begin
                    n.prdata = '0;
                    n.pslverr = 1'b1;
                end
            endcase
        end
        else if (acc && s.pready)
        begin
            n.pready = 1'b0;
            n.pslverr = 1'b0;
            if (PWRITE && PADDR == `OFS_CTRL)
                n.ctrl = PWDATA[1:0];
            // Sticky flags clear on read; a set below in this cycle wins
            if (!PWRITE && PADDR == `OFS_STATUS)
            begin
                n.rfault = 1'b0;
                n.ovfl = 1'b0;
            end
        end
        else
        begin
            n.pready = 1'b0;
            n.pslverr = 1'b0;
        end

        // ----------------------------------------
        // Transmit
        // ----------------------------------------
        fault_tx = s.fiber && !s.link && s.ctrl[`CTRL_FAULT_TX_EN]; // [RQ10] [RQ11]
        if (bit_en && s.fiber)
        begin
            if (fault_tx)
            begin
                tx_bit = (s.flt_pos != 7'(`FAULT_ONES)); // [RQ8]
                n.flt_pos = (s.flt_pos == 7'(`FAULT_ONES)) ? 7'h00 : s.flt_pos + 7'h01;
                n.tx_st = fx_pkg::TX_IDLE;
                n.tx_sym = `SYM_I;
                n.tx_pos = 3'h4;
            end
            else
            begin
                n.flt_pos = 7'h00;
                tx_bit = s.tx_sym[3'h4 - s.tx_pos]; // [RQ4]
                if (s.tx_pos != 3'h4)
                    n.tx_pos = s.tx_pos + 3'h1;
                else
                begin
                    n.tx_pos = 3'h0;
                    case (s.tx_st)
                        fx_pkg::TX_IDLE:
                        begin
                            if (TX_EN && s.ctrl[`CTRL_TX_ON])
                            begin
                                n.tx_sym = `SYM_J; // [RQ12]
                                n.tx_st = fx_pkg::TX_J;
                                n.tx_take = 1'b1;
                            end
                            else
                                n.tx_sym = `SYM_I; // [RQ13]
                        end
                        fx_pkg::TX_J:
                        begin
                            n.tx_sym = `SYM_K; // [RQ12]
                            n.tx_st = fx_pkg::TX_K;
                            n.tx_take = 1'b1;
                        end
                        fx_pkg::TX_K, fx_pkg::TX_DATA:
                        begin
                            if (TX_EN)
                            begin
                                n.tx_sym = fx_pkg::enc4b5b(TXD); // [RQ4]
                                n.tx_st = fx_pkg::TX_DATA;
                                n.tx_take = 1'b1;
                            end
                            else
                            begin
                                n.tx_sym = `SYM_T; // [RQ12]
                                n.tx_st = fx_pkg::TX_T;
                            end
                        end
                        fx_pkg::TX_T:
                        begin
                            n.tx_sym = `SYM_R; // [RQ12]
                            n.tx_st = fx_pkg::TX_R;
                        end
                        default:
                        begin
                            n.tx_sym = `SYM_I; // [RQ13]
                            n.tx_st = fx_pkg::TX_IDLE;
                        end
                    endcase
                end
            end
        end

        // ----------------------------------------
        // Receive: decoded bits enter symbol decoding directly
        // ----------------------------------------
        if (bit_en && s.fiber)
        begin
            sh = {s.rx_sh[8:0], rx_bit}; // [RQ5]
            n.rx_sh = sh;
            if (rx_bit)
            begin
                n.quiet = 6'h00;
                if (s.run != 7'(`FAULT_ONES + 1))
                    n.run = s.run + 7'h01; // [RQ15]
            end
            else
            begin
                n.run = 7'h00; // [RQ15]
                if (s.quiet != 6'(LOSS_BITS))
                    n.quiet = s.quiet + 6'h01;
                if (s.run == 7'(`FAULT_ONES)) // [RQ8] [RQ15]
                begin
                    if (s.hits == 2'(`FAULT_HITS - 1))
                        n.rfault = 1'b1; // [RQ9] [RQ11]
                    else
                        n.hits = s.hits + 2'h1;
                end
                else
                    n.hits = 2'h0;
            end

            // Idle-run and line-silence judge the link, not any pin
            if (n.run >= 7'(LINK_ONES))
                n.link = 1'b1; // [RQ6] [RQ7]
            if (n.quiet == 6'(LOSS_BITS))
            begin
                n.link = 1'b0; // [RQ6] [RQ7]
                n.in_frame = 1'b0;
            end

            if (!s.in_frame)
            begin
                if (sh == {`SYM_J, `SYM_K} && s.link)
                begin
                    n.in_frame = 1'b1;
                    n.rx_pos = 3'h0;
                end
            end
            else if (s.rx_pos != 3'h4)
                n.rx_pos = s.rx_pos + 3'h1;
            else
            begin
                n.rx_pos = 3'h0;
                sym = sh[4:0];
                // T ends the frame; the following R is ignored out of frame
                if (sym == `SYM_T || sym == `SYM_I)
                    n.in_frame = 1'b0;
                else
                begin
                    fifo_in_valid = 1'b1;
                    fifo_in = fx_pkg::dec5b4b(sym);
                    if (!fifo_in_ready)
                        n.ovfl = 1'b1;
                end
            end
        end

        // ----------------------------------------
        // Registered nibble output toward the MAC
        // ----------------------------------------
        fifo_out_ready = !s.rx_dv || RX_READY;
        if (fifo_out_valid && fifo_out_ready)
        begin
            n.rx_dv = 1'b1;
            n.rx_out = fifo_out;
        end
        else if (RX_READY)
            n.rx_dv = 1'b0;
    end

    // ----------------------------------------
    // State register
    // ----------------------------------------
    always_ff @(posedge CLK_SYS)
    begin
        if (RESET)
        begin
            s <= '0;
            s.ctrl <= `CTRL_RESET;
            s.tx_sym <= `SYM_I;
            s.tx_pos <= 3'h4;
        end
        else
            s <= n;
    end

    assign PREADY = s.pready;
    assign PRDATA = s.prdata;
    assign PSLVERR = s.pslverr;
    assign TX_TAKE = s.tx_take;
    assign RX_DV = s.rx_dv;
    assign RXD = s.rx_out.nib;
    assign RX_ERR = s.rx_out.err;
    assign LINK_UP = s.link;
    assign FIBER_MODE = s.fiber;

endmodule

// [fx_cfg.svh]
// Offsets, field positions, reset values and counts of the fiber port.
// Assumes inclusion by the package and modules by bare name.
`ifndef FX_CFG_SVH
`define FX_CFG_SVH

// ----------------------------------------
// Register map
// ----------------------------------------
`define OFS_CTRL 12'h000
`define OFS_STATUS 12'h004
`define CTRL_FAULT_TX_EN 0
`define CTRL_TX_ON 1
`define CTRL_RESET 2'h3
`define ST_LINK 2
`define ST_ANEG 3
`define ST_RFAULT 4
`define ST_FIBER 8
`define ST_OVFL 9

// ----------------------------------------
// Line code and timing
// ----------------------------------------
`define SYM_I 5'h1f
`define SYM_J 5'h18
`define SYM_K 5'h11
`define SYM_T 5'h0d
`define SYM_R 5'h07
`define FAULT_ONES 84
`define FAULT_HITS 3
`define LINK_ONES 10
`define LOSS_BITS 32
`define BIT_DIV 1
`define FIFO_DEPTH 16
`define FIFO_WIDTH 5

`endif

// [fx_pkg.sv]
// Types and code tables of the fiber port.
// Assumes fx_cfg.svh is reachable by bare name.
`include "fx_cfg.svh"

package fx_pkg;

    typedef enum logic [2:0] {
        TX_IDLE = 3'b000,
        TX_J = 3'b001,
        TX_K = 3'b010,
        TX_DATA = 3'b011,
        TX_T = 3'b100,
        TX_R = 3'b101
    } tx_state_e;

    typedef struct packed {
        logic err;
        logic [3:0] nib;
    } rx_word_s;

    typedef struct packed {
        logic init;
        logic fiber;
        logic [1:0] ctrl;
        logic [7:0] div;
        logic pready;
        logic pslverr;
        logic [31:0] prdata;
        tx_state_e tx_st;
        logic [4:0] tx_sym;
        logic [2:0] tx_pos;
        logic [6:0] flt_pos;
        logic tx_take;
        logic [9:0] rx_sh;
        logic in_frame;
        logic [2:0] rx_pos;
        logic [6:0] run;
        logic [5:0] quiet;
        logic link;
        logic [1:0] hits;
        logic rfault;
        logic ovfl;
        logic rx_dv;
        rx_word_s rx_out;
    } core_s;

    function automatic logic [4:0] enc4b5b(input logic [3:0] n);
        logic [4:0] t [16];
        t = '{5'h1e, 5'h09, 5'h14, 5'h15, 5'h0a, 5'h0b, 5'h0e, 5'h0f,
              5'h12, 5'h13, 5'h16, 5'h17, 5'h1a, 5'h1b, 5'h1c, 5'h1d};
        return t[n];
    endfunction

    function automatic rx_word_s dec5b4b(input logic [4:0] s);
        rx_word_s w;
        w.err = 1'b1;
        w.nib = 4'h7;
        for (int i = 0; i < 16; i++)
        begin
            if (enc4b5b(4'(i)) == s)
            begin
                w.err = 1'b0;
                w.nib = 4'(i);
            end
        end
        return w;
    endfunction

endpackage

// [fx_nrzi.sv]
// Two-level NRZI line coder: one transmit bit and one receive bit per enable.
// Assumes the receive line is already retimed to the system clock.
`timescale 1ns/1ps

module fx_nrzi
(
    input wire logic clk,
    input wire logic rst,
    input wire logic bit_en,
    input wire logic tx_on,
    input wire logic tx_bit,
    input wire logic rx_line,
    output logic tx_line,
    output logic rx_bit
);

    typedef struct packed {
        logic tx;
        logic rx_prev;
    } nrzi_s;

    nrzi_s s;
    nrzi_s n;

    always_comb
    begin
        n = s;
        if (bit_en)
        begin
            n.rx_prev = rx_line;
            if (!tx_on)
                n.tx = 1'b0;
            else if (tx_bit)
                n.tx = ~s.tx; // [RQ14]
        end
    end

    always_ff @(posedge clk)
    begin
        if (rst)
            s <= '0;
        else
            s <= n;
    end

    assign tx_line = s.tx;
    assign rx_bit = rx_line ^ s.rx_prev; // [RQ14]

endmodule

// [fx_fifo.sv]
// Flip-flop FIFO with valid/ready on both sides.
// Assumes one clock; depth is a power of two.
`timescale 1ns/1ps
`include "fx_cfg.svh"

module fx_fifo
#(
    parameter int W = `FIFO_WIDTH,
    parameter int D = `FIFO_DEPTH
)
(
    input wire logic clk,
    input wire logic rst,
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [W-1:0] in_data,
    output logic out_valid,
    input wire logic out_ready,
    output logic [W-1:0] out_data
);

    localparam int AW = $clog2(D);

    typedef struct packed {
        logic [D-1:0][W-1:0] mem;
        logic [AW-1:0] wp;
        logic [AW-1:0] rp;
        logic [AW:0] cnt;
    } fifo_s;

    fifo_s s;
    fifo_s n;
    logic push;
    logic pop;

    always_comb
    begin
        n = s;
        push = in_valid && in_ready;
        pop = out_valid && out_ready;
        if (push)
        begin
            n.mem[s.wp] = in_data;
            n.wp = s.wp + 1'b1;
        end
        if (pop)
            n.rp = s.rp + 1'b1;
        if (push && !pop)
            n.cnt = s.cnt + 1'b1;
        else if (pop && !push)
            n.cnt = s.cnt - 1'b1;
    end

    always_ff @(posedge clk)
    begin
        if (rst)
            s <= '0;
        else
            s <= n;
    end

    assign in_ready = (s.cnt != (AW+1)'(D));
    assign out_valid = (s.cnt != '0);
    assign out_data = s.mem[s.rp];

endmodule

// [fx_port_asserts.sv]
// Checker of the fiber port pins: bus answer, line code, link and fault runs.
// Assumes it is bound to fx_port and sees only its ports.
`timescale 1ns/1ps

module fx_port_asserts
#(
    parameter int LOSS_BITS = 32,
    parameter int LINK_ONES = 10
)
(
    input wire logic CLK_SYS,
    input wire logic RESET,
    input wire logic PSEL,
    input wire logic PENABLE,
    input wire logic PREADY,
    input wire logic TX_EN,
    input wire logic TX_TAKE,
    input wire logic FX_TX_LINE,
    input wire logic FX_RX_LINE,
    input wire logic RX_DV,
    input wire logic [3:0] RXD,
    input wire logic RX_ERR,
    input wire logic RX_READY,
    input wire logic LINK_UP,
    input wire logic FIBER_MODE
);
    // ----------------------------------------
    // Run counters on both lines and on the link state
    // ----------------------------------------
    logic pr_q, pt_q;
    logic [7:0] quiet_q, run_q, tog_q, down_q, idle_q;

    // Saturate so long quiet spells do not wrap into false runs
    function automatic logic [7:0] inc(input logic [7:0] v);
        return (v == 8'hff) ? v : v + 8'h01;
    endfunction

    always_ff @(posedge CLK_SYS)
    begin
        pr_q <= FX_RX_LINE;
        pt_q <= FX_TX_LINE;
        if (RESET)
        begin
            {quiet_q, run_q, tog_q, down_q, idle_q} <= 40'h0;
        end
        else
        begin
            quiet_q <= (FX_RX_LINE != pr_q) ? 8'h00 : inc(quiet_q);
            run_q <= (FX_RX_LINE != pr_q) ? inc(run_q) : 8'h00;
            tog_q <= (FX_TX_LINE != pt_q) ? inc(tog_q) : 8'h00;
            down_q <= (FIBER_MODE && !LINK_UP) ? inc(down_q) : 8'h00;
            idle_q <= (FIBER_MODE && LINK_UP && !TX_EN) ? inc(idle_q) : 8'h00;
        end
    end

    // ----------------------------------------
    // Properties
    // ----------------------------------------
    default clocking cb @(posedge CLK_SYS);
    endclocking
    default disable iff (RESET);

    sequence acc_s;
        PSEL && PENABLE && !PREADY;
    endsequence

    sequence gap_s;
        !TX_TAKE [*4];
    endsequence

    ready_time_a: assert property (acc_s |=> PREADY)
        else $error("bus answer not one cycle after access");
    ready_pulse_a: assert property (PREADY |=> !PREADY)
        else $error("bus answer longer than one cycle");
    take_gap_a: assert property (TX_TAKE |=> gap_s)
        else $error("nibble taken more often than once a symbol");
    fiber_quiet_a: assert property (!FIBER_MODE |-> !FX_TX_LINE)
        else $error("copper port drives the fiber line");
    rx_hold_a: assert property (RX_DV && !RX_READY |=> RX_DV && $stable({RX_ERR, RXD}))
        else $error("receive word changed before it was taken");
    link_down_a: assert property (quiet_q >= LOSS_BITS + 8 |-> !LINK_UP)
        else $error("link up on a line without transitions");
    link_up_a: assert property (FIBER_MODE && run_q >= LINK_ONES + 6 |-> LINK_UP)
        else $error("link down despite a run of ones");
    idle_tx_a: assert property (idle_q >= 100 |-> FX_TX_LINE != pt_q)
        else $error("idle stream holds the line");
    fault_run_a: assert property (down_q >= 200 && FX_TX_LINE == pt_q |-> tog_q == 84)
        else $error("fault pattern zero not after exactly 84 ones");
endmodule

// [fx_xcvr_model.sv]
// Fiber transceiver stand-in: sends queued bits as NRZI and decodes the port line.
// Assumes one line bit per system clock.
`timescale 1ns/1ps

module fx_xcvr_model
(
    input wire logic clk,
    input wire logic tx_line,
    output logic rx_line
);
    bit sq[$];
    bit cap[$];
    bit idle = 1'b1;
    logic pt_q = 1'b0;

    initial rx_line = 1'b0;

    // A dark fibre holds one level, so idle off means no transitions at all
    always @(posedge clk)
    begin
        if (sq.size() != 0)
            rx_line <= rx_line ^ sq.pop_front();
        else
            rx_line <= rx_line ^ idle;
        cap.push_back(tx_line ^ pt_q);
        pt_q <= tx_line;
    end

    task automatic put(input logic [4:0] v);
        for (int i = 4; i >= 0; i--)
            sq.push_back(v[i]);
    endtask

    task automatic fault(input int ones);
        repeat (ones) sq.push_back(1'b1);
        sq.push_back(1'b0);
    endtask
endmodule

// [tb_top.sv]
// Self-checking bench of one fiber port: straps, registers, transmit, receive, fault.
// Assumes fx_pkg, fx_port, the checker and the transceiver model are compiled.
`timescale 1ns/1ps
`include "fx_cfg.svh"

module tb_top;
    localparam logic [4:0] ENC [16] = '{5'h1e, 5'h09, 5'h14, 5'h15, 5'h0a, 5'h0b, 5'h0e,
        5'h0f, 5'h12, 5'h13, 5'h16, 5'h17, 5'h1a, 5'h1b, 5'h1c, 5'h1d};
    logic clk = 1'b0;
    logic reset = 1'b1;
    logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, tx_en = 1'b0, rx_ready = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0, rs = 32'h768692c5, prdata, r;
    logic pready, pslverr, tx_take, tx_line, rx_line, rx_dv, rx_err, link_up, fiber_mode, e;
    logic [1:0] strap = 2'h0;
    logic [3:0] txd = 4'h0, rxd;
    int err_count = 0, checked = 0, cyc = 0;

    fx_port fx_port_i (.CLK_SYS(clk), .RESET(reset), .PSEL(psel), .PENABLE(penable),
        .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PREADY(pready), .PRDATA(prdata),
        .PSLVERR(pslverr), .MEDIUM_SELECT_STRAP(strap), .PORT_PAIR_LOOPBACK_STRAP(1'b0),
        .TX_EN(tx_en), .TXD(txd), .TX_TAKE(tx_take), .FX_TX_LINE(tx_line),
        .FX_RX_LINE(rx_line), .RX_DV(rx_dv), .RXD(rxd), .RX_ERR(rx_err),
        .RX_READY(rx_ready), .LINK_UP(link_up), .FIBER_MODE(fiber_mode));
    fx_xcvr_model fx_xcvr_model_i (.clk(clk), .tx_line(tx_line), .rx_line(rx_line));

    // ----------------------------------------
    // Tasks
    // ----------------------------------------
    function automatic logic [31:0] xs(input logic [31:0] x);
        x ^= x << 13;
        x ^= x >> 17;
        x ^= x << 5;
        return x;
    endfunction

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp)
        begin
            err_count++;
            $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic close_out();
        $display("comparisons %0d mismatches %0d", checked, err_count);
        if (err_count == 0 && checked > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask

    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        do @(posedge clk); while (pready !== 1'b1);
        r = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic settle();
        while (fx_xcvr_model_i.sq.size() != 0)
            @(posedge clk);
        repeat (20) @(posedge clk);
    endtask

    initial
    begin
        forever #10 clk = ~clk;
    end

    always @(posedge clk)
    begin
        cyc++;
        if (cyc == 20000)
        begin
            err_count++;
            close_out();
        end
    end

    // ----------------------------------------
    // Scenarios
    // ----------------------------------------
    initial
    begin
        int n, k, z, got;
        int runs [5];
        logic [4:0] s;
        logic [4:0] es[$];
        logic [4:0] q[$];
        runs = '{84, 84, 83, 84, 84};
        for (int i = 0; i < 4; i++)
        begin
            strap <= 2'(i);
            reset <= 1'b1;
            repeat (8) @(posedge clk);
            reset <= 1'b0;
            repeat (3) @(posedge clk);
            chk(fiber_mode, i != 0);
            apb(1'b0, `OFS_STATUS, 32'h0);
            chk({r[8], r[3]}, {i != 0, i == 0});
        end
        $display("strap test done");
        apb(1'b0, `OFS_CTRL, 32'h0);
        chk(r, 32'h3);
        apb(1'b0, 12'h010, 32'h0);
        chk({e, r[30:0]}, 32'h80000000);
        apb(1'b1, `OFS_CTRL, 32'h3);
        $display("register test done");
        fx_xcvr_model_i.idle <= 1'b0;
        repeat (300) @(posedge clk);
        fx_xcvr_model_i.cap.delete();
        repeat (400) @(posedge clk);
        chk(link_up, 1'b0);
        n = 0;
        k = -1;
        foreach (fx_xcvr_model_i.cap[i])
        begin
            if (fx_xcvr_model_i.cap[i])
                n++;
            else
            begin
                if (k >= 0 && k < 3)
                    chk(n, 84);
                k++;
                n = 0;
            end
        end
        chk(k >= 3, 1'b1);
        $display("fault transmit test done");
        fx_xcvr_model_i.idle <= 1'b1;
        repeat (40) if (link_up !== 1'b1) @(posedge clk);
        chk(link_up, 1'b1);
        repeat (150) @(posedge clk);
        fx_xcvr_model_i.cap.delete();
        es = '{`SYM_J, `SYM_K};
        for (int i = 0; i < 8; i++)
        begin
            rs = xs(rs);
            txd <= rs[3:0];
            tx_en <= 1'b1;
            if (i > 1)
                es.push_back(ENC[rs[3:0]]);
            do @(posedge clk); while (tx_take !== 1'b1);
        end
        tx_en <= 1'b0;
        es = {es, `SYM_T, `SYM_R, `SYM_I, `SYM_I};
        repeat (100) @(posedge clk);
        z = 0;
        while (z < 1000 && fx_xcvr_model_i.cap[z] == 1'b1)
            z++;
        foreach (es[j])
        begin
            for (int b = 0; b < 5; b++)
                s = {s[3:0], fx_xcvr_model_i.cap[z - 2 + 5 * j + b]};
            chk(s, es[j]);
        end
        $display("transmit frame test done");
        rx_ready <= 1'b0;
        fx_xcvr_model_i.put(`SYM_J);
        fx_xcvr_model_i.put(`SYM_K);
        for (int i = 0; i < 20; i++)
        begin
            rs = xs(rs);
            fx_xcvr_model_i.put((i == 3) ? 5'h04 : ENC[rs[3:0]]);
            q.push_back((i == 3) ? 5'h17 : {1'b0, rs[3:0]});
        end
        fx_xcvr_model_i.put(`SYM_T);
        fx_xcvr_model_i.put(`SYM_R);
        settle();
        apb(1'b0, `OFS_STATUS, 32'h0);
        chk(r[9], 1'b1);
        got = 0;
        repeat (300)
        begin
            @(posedge clk);
            if (rx_dv === 1'b1 && rx_ready === 1'b1)
            begin
                chk({rx_err, rxd}, q.pop_front());
                got++;
            end
            rs = xs(rs);
            rx_ready <= rs[0];
        end
        chk(got >= 16, 1'b1);
        apb(1'b0, `OFS_STATUS, 32'h0);
        chk(r[9], 1'b0);
        $display("receive test done");
        // Idle ones run into the first pattern, so it never counts as a hit;
        // the third hit must follow without idle between, so read mid-pattern
        foreach (runs[j])
            fx_xcvr_model_i.fault(runs[j]);
        fx_xcvr_model_i.fault(84);
        while (fx_xcvr_model_i.sq.size() > 40)
            @(posedge clk);
        apb(1'b0, `OFS_STATUS, 32'h0);
        chk(r[4], 1'b0);
        settle();
        apb(1'b0, `OFS_STATUS, 32'h0);
        chk(r[4], 1'b1);
        apb(1'b0, `OFS_STATUS, 32'h0);
        chk(r[4], 1'b0);
        $display("remote fault test done");
        close_out();
    end
endmodule

bind fx_port fx_port_asserts #(.LOSS_BITS(LOSS_BITS), .LINK_ONES(LINK_ONES)) fx_port_asserts_i (
    .CLK_SYS(CLK_SYS), .RESET(RESET), .PSEL(PSEL), .PENABLE(PENABLE), .PREADY(PREADY),
    .TX_EN(TX_EN), .TX_TAKE(TX_TAKE), .FX_TX_LINE(FX_TX_LINE), .FX_RX_LINE(FX_RX_LINE),
    .RX_DV(RX_DV), .RXD(RXD), .RX_ERR(RX_ERR), .RX_READY(RX_READY), .LINK_UP(LINK_UP),
    .FIBER_MODE(FIBER_MODE));
